// File: rtl/fsp_top.sv
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/100ps
module fsp_top import fsp_pkg::*; (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // ahb-lite slave
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    // nonvolatile protection byte from the array
    input wire logic [7:0] i_nv_prot_byte,
    // command launch handshake from the command sequencer
    input wire logic i_cmd_valid,
    input wire logic [1:0] i_cmd_kind,
    input wire logic [15:0] i_cmd_addr,
    output logic o_cmd_ready,
    output logic o_cmd_launch,
    output logic o_cmd_refused,
    // status towards the rest of the memory module
    output logic [7:0] o_config,
    output logic o_violation,
    output logic o_mass_erase_ok,
    output logic o_loaded,
    // interrupt
    output logic o_irq
);

    // ==========================================================
    // state and registers
    fsp_state_e state_r;
    logic [7:0] config_r;
    logic [7:0] config_nxt;
    logic violation_r;

    // bus pipeline
    logic ap_valid;
    logic wr_pend_r;
    logic rd_wait_r;
    logic [7:0] addr_r;
    logic [31:0] hrdata_r;

    // decoded fields of the active setting
    logic polarity;
    logic upper_off;
    logic lower_off;
    logic [1:0] upper_size;
    logic [1:0] lower_size;

    // range hits and the protection verdict
    logic upper_hit;
    logic lower_hit;
    logic in_active_range;
    logic addr_protected;
    logic mass_ok;
    logic cmd_take;
    logic cmd_bad;

    // register strobes
    logic wr_config;
    logic wr_status;
    logic wr_mask;
    logic rd_int_clr;
    logic scenario_ok;

    // interrupt controller wires
    logic [FSP_EVT_NUM-1:0] evt;
    logic [FSP_EVT_NUM-1:0] int_status;
    logic [FSP_EVT_NUM-1:0] int_mask;

    // ==========================================================
    // field decode
    assign polarity = config_r[FSP_BIT_POLARITY];
    assign upper_off = config_r[FSP_BIT_UPPER_OFF];
    assign lower_off = config_r[FSP_BIT_LOWER_OFF];
    assign upper_size = config_r[FSP_UPPER_SIZE_HI:FSP_UPPER_SIZE_LO];
    assign lower_size = config_r[FSP_LOWER_SIZE_HI:FSP_LOWER_SIZE_LO];

    // ==========================================================
    // range decoders; the two ranges never overlap
    fsp_range_hit #(
        .IS_UPPER(1'b1)
    ) u_upper (
        .i_size(upper_size),
        .i_addr(i_cmd_addr),
        .o_hit(upper_hit)
    );

    fsp_range_hit #(
        .IS_UPPER(1'b0)
    ) u_lower (
        .i_size(lower_size),
        .i_addr(i_cmd_addr),
        .o_hit(lower_hit)
    );

    // a range takes part only while its off bit is clear
    assign in_active_range = (upper_hit & ~upper_off)
                           | (lower_hit & ~lower_off);

    // polarity 1: active ranges are protected; polarity 0: only they are open
    assign addr_protected = polarity ? in_active_range : ~in_active_range;

    // mass erase needs every protection switched off
    assign mass_ok = polarity & upper_off & lower_off;
    assign o_mass_erase_ok = mass_ok;

    // ==========================================================
    // command launch gate, checked combinationally against the live setting
    // a pending violation or the reset load holds off every new command
    assign o_cmd_ready = (state_r == FSP_ST_RUN) & ~violation_r;
    assign cmd_take = i_cmd_valid & o_cmd_ready;

    always_comb begin
        if (i_cmd_kind == FSP_CMD_MASS_ERASE) begin
            cmd_bad = ~mass_ok;
        end else begin
            cmd_bad = addr_protected;
        end
    end

    assign o_cmd_launch = cmd_take & ~cmd_bad;
    assign o_cmd_refused = cmd_take & cmd_bad;

    // ==========================================================
    // control state: one load cycle after reset release, then run
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state_r <= FSP_ST_LOAD;
        end else begin
            case (state_r)
                FSP_ST_LOAD: state_r <= FSP_ST_RUN;
                FSP_ST_RUN: state_r <= FSP_ST_RUN;
                default: state_r <= FSP_ST_LOAD;
            endcase
        end
    end

    assign o_loaded = (state_r == FSP_ST_RUN);

    // ==========================================================
    // ahb-lite address phase capture
    assign ap_valid = i_hsel & i_htrans[1] & i_hready;

    // writes complete with no wait; reads take one wait cycle so that the
    // read data come from a flop and a read right after a write sees it
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            wr_pend_r <= 1'b0;
            rd_wait_r <= 1'b0;
            addr_r <= 8'h00;
        end else begin
            if (rd_wait_r) begin
                rd_wait_r <= 1'b0;
            end else begin
                wr_pend_r <= ap_valid & i_hwrite;
                rd_wait_r <= ap_valid & ~i_hwrite;
                if (ap_valid) begin
                    addr_r <= i_haddr[7:0];
                end
            end
        end
    end

    // bus answer: one wait cycle in a read data phase, always okay
    assign o_hreadyout = ~rd_wait_r;
    assign o_hresp = 1'b0;
    assign o_hrdata = hrdata_r;

    // ==========================================================
    // write strobes and the int status read-clear strobe, only whole-word aligned addresses decode
    assign wr_config = wr_pend_r & (addr_r == FSP_OFS_CONFIG) & (state_r == FSP_ST_RUN);
    assign wr_status = wr_pend_r & (addr_r == FSP_OFS_STATUS);
    assign wr_mask = wr_pend_r & (addr_r == FSP_OFS_INT_MASK);
    assign rd_int_clr = rd_wait_r & (addr_r == FSP_OFS_INT_STATUS);

    // ==========================================================
    // candidate value: per-field write restrictions applied first
    always_comb begin
        config_nxt = config_r;
        config_nxt[FSP_BIT_POLARITY] = polarity & i_hwdata[FSP_BIT_POLARITY];
        config_nxt[FSP_BIT_UPPER_OFF] = i_hwdata[FSP_BIT_UPPER_OFF];
        config_nxt[FSP_BIT_LOWER_OFF] = i_hwdata[FSP_BIT_LOWER_OFF];
        if (upper_off) begin
            config_nxt[FSP_UPPER_SIZE_HI:FSP_UPPER_SIZE_LO] =
                i_hwdata[FSP_UPPER_SIZE_HI:FSP_UPPER_SIZE_LO];
        end
        if (lower_off) begin
            config_nxt[FSP_LOWER_SIZE_HI:FSP_LOWER_SIZE_LO] =
                i_hwdata[FSP_LOWER_SIZE_HI:FSP_LOWER_SIZE_LO];
        end
    end

    // ==========================================================
    // scenario check: the protected set may only grow. ranges are nested by
    // size and the two ranges are disjoint, so a per-range test is exact.
    always_comb begin
        logic n_pol;
        logic n_uact;
        logic n_lact;
        logic o_uact;
        logic o_lact;
        logic [1:0] n_usz;
        logic [1:0] n_lsz;
        n_pol = config_nxt[FSP_BIT_POLARITY];
        n_uact = ~config_nxt[FSP_BIT_UPPER_OFF];
        n_lact = ~config_nxt[FSP_BIT_LOWER_OFF];
        o_uact = ~upper_off;
        o_lact = ~lower_off;
        n_usz = config_nxt[FSP_UPPER_SIZE_HI:FSP_UPPER_SIZE_LO];
        n_lsz = config_nxt[FSP_LOWER_SIZE_HI:FSP_LOWER_SIZE_LO];
        if (polarity && n_pol) begin
            // each protected range must stay, at least as large
            scenario_ok = (~o_uact | (n_uact & (n_usz >= upper_size)))
                        & (~o_lact | (n_lact & (n_lsz >= lower_size)));
        end else if (polarity) begin
            // turning open ranges into the only unprotected ones
            scenario_ok = (~o_uact | ~n_uact) & (~o_lact | ~n_lact);
        end else if (!n_pol) begin
            // unprotected windows may only shrink or close
            scenario_ok = (~n_uact | (o_uact & (n_usz <= upper_size)))
                        & (~n_lact | (o_lact & (n_lsz <= lower_size)));
        end else begin
            scenario_ok = 1'b0;
        end
    end

    // ==========================================================
    // protection config: loaded once after reset, then guarded writes.
    // the byte is caught by a clocked load, never by the reset itself.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            config_r <= FSP_CONFIG_RST;
        end else if (state_r == FSP_ST_LOAD) begin
            config_r <= i_nv_prot_byte;
        end else if (wr_config && scenario_ok) begin
            config_r <= config_nxt;
        end
    end

    assign o_config = config_r;

    // ==========================================================
    // violation flag: write 1 clears, a new refusal in the same cycle wins
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            violation_r <= 1'b0;
        end else if (o_cmd_refused) begin
            violation_r <= 1'b1;
        end else if (wr_status && i_hwdata[FSP_BIT_VIOLATION]) begin
            violation_r <= 1'b0;
        end
    end

    assign o_violation = violation_r;

    // ==========================================================
    // interrupt events and controller
    assign evt[FSP_EVT_VIOLATION] = o_cmd_refused;
    assign evt[FSP_EVT_LAUNCH] = o_cmd_launch;

    fsp_evt_ctl #(
        .N(FSP_EVT_NUM)
    ) u_evt (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_evt(evt),
        .i_clr_rd(rd_int_clr),
        .i_mask_wr(wr_mask),
        .i_mask_wdata(i_hwdata[FSP_EVT_NUM-1:0]),
        .o_status(int_status),
        .o_mask(int_mask),
        .o_irq(o_irq)
    );

    // ==========================================================
    // read data register, loaded during the read wait cycle.
    // no mode input gates it: the config reads the same in every mode.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            hrdata_r <= 32'h0000_0000;
        end else if (rd_wait_r) begin
            case (addr_r)
                FSP_OFS_CONFIG: hrdata_r <= {24'h00_0000, config_r};
                FSP_OFS_STATUS: hrdata_r <= 32'(violation_r) << FSP_BIT_VIOLATION;
                FSP_OFS_INT_STATUS: hrdata_r <= {30'h0000_0000, int_status};
                FSP_OFS_INT_MASK: hrdata_r <= {30'h0000_0000, int_mask};
                default: hrdata_r <= 32'h0000_0000; // unmapped reads zero
            endcase
        end
    end

    // spare flag and unused bus fields are carried but have no effect here;
    // the operator keeps the spare bit erased and reprograms the nonvolatile
    // byte only after opening the upper sector
    logic unused_ok;
    assign unused_ok = ^{config_r[FSP_BIT_SPARE], i_hsize, i_haddr[31:8], i_hwdata[31:8],
                         i_htrans[0], FSP_NV_PROT_ADDR};

endmodule : fsp_top

// File: rtl/fsp_pkg.sv
package fsp_pkg;

    // ==========================================================
    // register map, byte addresses on the bus
    localparam logic [7:0] FSP_OFS_CONFIG = 8'h04;
    localparam logic [7:0] FSP_OFS_STATUS = 8'h08;
    localparam logic [7:0] FSP_OFS_INT_STATUS = 8'h0C;
    localparam logic [7:0] FSP_OFS_INT_MASK = 8'h10;

    // ==========================================================
    // protection config field positions
    localparam int FSP_BIT_POLARITY = 7;
    localparam int FSP_BIT_SPARE = 6;
    localparam int FSP_BIT_UPPER_OFF = 5;
    localparam int FSP_UPPER_SIZE_HI = 4;
    localparam int FSP_UPPER_SIZE_LO = 3;
    localparam int FSP_BIT_LOWER_OFF = 2;
    localparam int FSP_LOWER_SIZE_HI = 1;
    localparam int FSP_LOWER_SIZE_LO = 0;

    // status register field position (violation flag)
    localparam int FSP_BIT_VIOLATION = 5;

    // ==========================================================
    // nonvolatile protection byte location and reset values
    localparam logic [15:0] FSP_NV_PROT_ADDR = 16'hFF0D;
    localparam logic [7:0] FSP_CONFIG_RST = 8'hFF;
    localparam logic [1:0] FSP_INT_MASK_RST = 2'h0;

    // ==========================================================
    // interrupt event bits
    localparam int FSP_EVT_NUM = 2;
    localparam int FSP_EVT_VIOLATION = 0;
    localparam int FSP_EVT_LAUNCH = 1;

    // ==========================================================
    // range tables: upper ranges end at top, lower ranges start at base
    localparam logic [15:0] FSP_UPPER_END = 16'hFFFF;
    localparam logic [15:0] FSP_UPPER_START_0 = 16'hF800;
    localparam logic [15:0] FSP_UPPER_START_1 = 16'hF000;
    localparam logic [15:0] FSP_UPPER_START_2 = 16'hE000;
    localparam logic [15:0] FSP_UPPER_START_3 = 16'hC000;
    localparam logic [15:0] FSP_LOWER_START = 16'h4000;
    localparam logic [15:0] FSP_LOWER_END_0 = 16'h43FF;
    localparam logic [15:0] FSP_LOWER_END_1 = 16'h47FF;
    localparam logic [15:0] FSP_LOWER_END_2 = 16'h4FFF;
    localparam logic [15:0] FSP_LOWER_END_3 = 16'h5FFF;

    // ==========================================================
    // command kinds and control states
    localparam logic [1:0] FSP_CMD_PROGRAM = 2'h0;
    localparam logic [1:0] FSP_CMD_ERASE = 2'h1;
    localparam logic [1:0] FSP_CMD_MASS_ERASE = 2'h2;

    typedef enum logic [1:0] {
        FSP_ST_LOAD = 2'b01,
        FSP_ST_RUN = 2'b10
    } fsp_state_e;

endpackage : fsp_pkg

// File: rtl/fsp_range_hit.sv
`timescale 1ns/100ps
module fsp_range_hit import fsp_pkg::*; #(
    parameter bit IS_UPPER = 1'b1
) (
    // range selection
    input wire logic [1:0] i_size,
    // address under test
    input wire logic [15:0] i_addr,
    // result
    output logic o_hit
);

    // ==========================================================
    // size decode: upper ranges grow downward, lower ones upward
    logic [15:0] lo_bound;
    logic [15:0] hi_bound;

    always_comb begin
        if (IS_UPPER) begin
            hi_bound = FSP_UPPER_END;
            case (i_size)
                2'h0: lo_bound = FSP_UPPER_START_0;
                2'h1: lo_bound = FSP_UPPER_START_1;
                2'h2: lo_bound = FSP_UPPER_START_2;
                default: lo_bound = FSP_UPPER_START_3;
            endcase
        end else begin
            lo_bound = FSP_LOWER_START;
            case (i_size)
                2'h0: hi_bound = FSP_LOWER_END_0;
                2'h1: hi_bound = FSP_LOWER_END_1;
                2'h2: hi_bound = FSP_LOWER_END_2;
                default: hi_bound = FSP_LOWER_END_3;
            endcase
        end
    end

    // inclusive compare on both bounds
    assign o_hit = (i_addr >= lo_bound) && (i_addr <= hi_bound);

endmodule : fsp_range_hit

// File: rtl/fsp_evt_ctl.sv
`timescale 1ns/100ps
module fsp_evt_ctl import fsp_pkg::*; #(
    parameter int N = 2
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // event pulses from the block
    input wire logic [N-1:0] i_evt,
    // register access
    input wire logic i_clr_rd,
    input wire logic i_mask_wr,
    input wire logic [N-1:0] i_mask_wdata,
    // state out
    output logic [N-1:0] o_status,
    output logic [N-1:0] o_mask,
    output logic o_irq
);

    logic [N-1:0] status_r;
    logic [N-1:0] mask_r;

    // ==========================================================
    // sticky bits, cleared by a read; a same-cycle event survives the clear
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            status_r <= '0;
        end else if (i_clr_rd) begin
            status_r <= i_evt;
        end else begin
            status_r <= status_r | i_evt;
        end
    end

    // mask register, same layout as status
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            mask_r <= N'(FSP_INT_MASK_RST);
        end else if (i_mask_wr) begin
            mask_r <= i_mask_wdata;
        end
    end

    assign o_status = status_r;
    assign o_mask = mask_r;
    assign o_irq = |(status_r & mask_r);

endmodule : fsp_evt_ctl

// File: bench/fsp_properties.sv
`timescale 1ns/100ps
// ==========================================================
// checker on the top ports, one clock domain
module fsp_checker import fsp_pkg::*; (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // bus
    input wire logic i_hsel,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic i_hready,
    input wire logic o_hreadyout,
    input wire logic o_hresp,
    // load and command
    input wire logic [7:0] i_nv_prot_byte,
    input wire logic i_cmd_valid,
    input wire logic [1:0] i_cmd_kind,
    input wire logic [15:0] i_cmd_addr,
    input wire logic o_cmd_ready,
    input wire logic o_cmd_launch,
    input wire logic o_cmd_refused,
    input wire logic [7:0] o_config,
    input wire logic o_violation,
    input wire logic o_mass_erase_ok,
    input wire logic o_loaded
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // the taken-command term ties every verdict to its cause
    wire logic taken = i_cmd_valid && o_cmd_ready;
    read_wait_a: assert property (i_hsel && i_htrans[1] && !i_hwrite && i_hready |=> !o_hreadyout ##1 o_hreadyout)
        else $error("read data phase not one wait state");
    hresp_okay_a: assert property (o_hresp == 1'b0)
        else $error("bus response not okay");
    load_nv_a: assert property ($rose(o_loaded) |-> o_config == $past(i_nv_prot_byte))
        else $error("config not loaded from nonvolatile byte");
    pol_no_rise_a: assert property (o_loaded && $past(o_loaded) && !$past(o_config[7]) |-> !o_config[7])
        else $error("polarity bit returned to one");
    lsize_locked_a: assert property (o_loaded && $past(o_loaded) && !$past(o_config[2]) |-> $stable(o_config[1:0]))
        else $error("lower size changed while range on");
    usize_locked_a: assert property (o_loaded && $past(o_loaded) && !$past(o_config[5]) |-> $stable(o_config[4:3]))
        else $error("upper size changed while range on");
    mass_decode_a: assert property (o_mass_erase_ok == (o_config[7] && o_config[5] && o_config[2]))
        else $error("mass erase permission wrong");
    mass_refuse_a: assert property (taken && i_cmd_kind == 2'h2 && !o_mass_erase_ok |-> o_cmd_refused)
        else $error("mass erase not refused");
    one_verdict_a: assert property (taken |-> o_cmd_launch ^ o_cmd_refused)
        else $error("command verdict missing or doubled");
    refuse_flag_a: assert property (o_cmd_refused |=> o_violation)
        else $error("refusal did not set violation");
    viol_blocks_a: assert property (o_violation |-> !o_cmd_ready && !o_cmd_launch)
        else $error("command accepted while violation set");
    top_protect_a: assert property (taken && i_cmd_kind != 2'h2 && o_config[7] && !o_config[5]
        && i_cmd_addr == 16'hFFFF |-> o_cmd_refused)
        else $error("top address not protected");
endmodule : fsp_checker

bind fsp_top fsp_checker u_chk (.i_clk(i_clk), .i_rst(i_rst), .i_hsel(i_hsel), .i_htrans(i_htrans),
    .i_hwrite(i_hwrite), .i_hready(i_hready), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
    .i_nv_prot_byte(i_nv_prot_byte), .i_cmd_valid(i_cmd_valid), .i_cmd_kind(i_cmd_kind),
    .i_cmd_addr(i_cmd_addr), .o_cmd_ready(o_cmd_ready), .o_cmd_launch(o_cmd_launch),
    .o_cmd_refused(o_cmd_refused), .o_config(o_config), .o_violation(o_violation),
    .o_mass_erase_ok(o_mass_erase_ok), .o_loaded(o_loaded));

// File: bench/flash_sector_protection_tb_top.sv
`timescale 1ns/100ps
// ==========================================================
// self-checking bench, bus and command driven directly
module flash_sector_protection_tb_top import fsp_pkg::*;;
    logic i_clk = 1'b0, i_rst = 1'b1, i_hsel = 1'b0, i_hwrite = 1'b0, i_cmd_valid = 1'b0;
    logic [31:0] i_haddr = 32'h0, i_hwdata = 32'h0, o_hrdata;
    logic [1:0] i_htrans = 2'h0, i_cmd_kind = 2'h0;
    logic [7:0] i_nv_prot_byte = 8'hFF, o_config;
    logic [15:0] i_cmd_addr = 16'h0;
    logic o_hreadyout, o_hresp, o_cmd_ready, o_cmd_launch, o_cmd_refused;
    logic o_violation, o_mass_erase_ok, o_loaded, o_irq;
    int err_total = 0, n_compared = 0;
    // 25 MHz
    always #20 i_clk = ~i_clk;
    fsp_top u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans),
        .i_hwrite(i_hwrite), .i_hsize(3'h2), .i_hwdata(i_hwdata), .i_hready(o_hreadyout), .o_hrdata(o_hrdata),
        .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .i_nv_prot_byte(i_nv_prot_byte),
        .i_cmd_valid(i_cmd_valid), .i_cmd_kind(i_cmd_kind), .i_cmd_addr(i_cmd_addr),
        .o_cmd_ready(o_cmd_ready), .o_cmd_launch(o_cmd_launch), .o_cmd_refused(o_cmd_refused),
        .o_config(o_config), .o_violation(o_violation), .o_mass_erase_ok(o_mass_erase_ok),
        .o_loaded(o_loaded), .o_irq(o_irq));
    // ==========================================================
    // reporting
    task print_verdict();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : print_verdict
    task chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    // ==========================================================
    // bus cycles; the wait is bounded so a stuck slave ends the run
    task wait_rdy();
        int n;
        n = 0;
        @(posedge i_clk);
        while (o_hreadyout !== 1'b1 && n < 50) begin
            @(posedge i_clk);
            n++;
        end
        if (o_hreadyout !== 1'b1) begin
            err_total++;
            print_verdict();
        end
    endtask : wait_rdy
    // every change starts right after a rising edge; the closing pause lets register updates settle
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
        @(posedge i_clk);
        i_hsel <= 1'b1;
        i_haddr <= {24'h0, a};
        i_htrans <= 2'h2;
        i_hwrite <= w;
        wait_rdy();
        i_htrans <= 2'h0;
        i_hwdata <= d;
        wait_rdy();
        if (!w) chk(o_hrdata, e);
        #1;
    endtask : xfer
    task wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, 32'h0);
    endtask : wr
    task rd(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0, e);
    endtask : rd
    // one command; a refusal is checked, then cleared by writing one
    task cmd(input logic [1:0] k, input logic [15:0] a, input logic ok);
        @(posedge i_clk);
        i_cmd_valid <= 1'b1;
        i_cmd_kind <= k;
        i_cmd_addr <= a;
        @(negedge i_clk);
        chk(o_cmd_launch, ok);
        chk(o_cmd_refused, !ok);
        @(posedge i_clk);
        i_cmd_valid <= 1'b0;
        if (!ok) begin
            @(negedge i_clk);
            chk(o_cmd_ready, 1'b0);
            wr(FSP_OFS_STATUS, 32'h0);
            chk(o_violation, 1'b1);
            wr(FSP_OFS_STATUS, 32'h20);
            chk(o_violation, 1'b0);
        end
    endtask : cmd
    task do_rst(input logic [7:0] nv);
        i_nv_prot_byte <= nv;
        i_rst <= 1'b1;
        repeat (20) @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
        @(negedge i_clk);
        chk(o_config, nv);
        chk(o_loaded, 1'b1);
    endtask : do_rst
    // ==========================================================
    // scenarios; every byte used keeps the spare bit 6 erased (one)
    task t_open();
        rd(FSP_OFS_CONFIG, 32'hFF);
        cmd(2'h2, 16'h0, 1'b1);
        cmd(2'h0, 16'hFFFF, 1'b1);
        cmd(2'h1, 16'h4000, 1'b1);
        chk(o_irq, 1'b0);
        wr(FSP_OFS_INT_MASK, 32'h3);
        chk(o_irq, 1'b1);
        rd(FSP_OFS_INT_STATUS, 32'h2);
        chk(o_irq, 1'b0);
        rd(8'h20, 32'h0);
        $display("t_open done");
    endtask : t_open
    task t_ranges();
        wr(FSP_OFS_CONFIG, 32'hEE);
        rd(FSP_OFS_CONFIG, 32'hEE);
        wr(FSP_OFS_CONFIG, 32'hCA);
        rd(FSP_OFS_CONFIG, 32'hCA);
        cmd(2'h0, 16'hEFFF, 1'b1);
        cmd(2'h1, 16'hF000, 1'b0);
        cmd(2'h0, 16'hFFFF, 1'b0);
        cmd(2'h0, 16'h3FFF, 1'b1);
        cmd(2'h1, 16'h4FFF, 1'b0);
        cmd(2'h0, 16'h5000, 1'b1);
        cmd(2'h2, 16'h0, 1'b0);
        chk(o_irq, 1'b1);
        rd(FSP_OFS_INT_STATUS, 32'h3);
        wr(FSP_OFS_CONFIG, 32'hDB);
        rd(FSP_OFS_CONFIG, 32'hCA);
        wr(FSP_OFS_CONFIG, 32'hEA);
        rd(FSP_OFS_CONFIG, 32'hCA);
        wr(FSP_OFS_CONFIG, 32'h4A);
        rd(FSP_OFS_CONFIG, 32'hCA);
        $display("t_ranges done");
    endtask : t_ranges
    // inverted polarity: only the two sized windows stay open; the new
    // nonvolatile byte only appears across a reset, never by a bus write
    task t_pol0();
        do_rst(8'h5A);
        rd(FSP_OFS_CONFIG, 32'h5A);
        cmd(2'h0, 16'hC000, 1'b1);
        cmd(2'h1, 16'hBFFF, 1'b0);
        cmd(2'h0, 16'h4FFF, 1'b1);
        cmd(2'h0, 16'h5000, 1'b0);
        cmd(2'h1, 16'h8000, 1'b0);
        cmd(2'h2, 16'h0, 1'b0);
        wr(FSP_OFS_CONFIG, 32'hDA);
        rd(FSP_OFS_CONFIG, 32'h5A);
        $display("t_pol0 done");
    endtask : t_pol0
    initial begin
        do_rst(8'hFF);
        t_open();
        t_ranges();
        t_pol0();
        print_verdict();
    end
endmodule : flash_sector_protection_tb_top
